// File: emx_consts.svh
`ifndef EMX_CONSTS_SVH
`define EMX_CONSTS_SVH

// ----------------------------------------
// Cycle budget and field positions
// ----------------------------------------
`define EMX_MOVE_CYCLES 3
`define EMX_CODE_BYTES 1
`define EMX_CFG_MUX_BIT 4
`define EMX_CFG_RESET 8'h00
`define EMX_LOW_BYTE_W 8
`define EMX_ADDR_W 16

`endif

// File: emx_mem_model.sv
`timescale 1ns/1ps
module emx_mem_model (
	input wire logic [7:0] ad_out_i, // Device drive.
	input wire logic ad_oe_i, // Device drives.
	input wire logic [7:0] addr_hi_i, // Upper address.
	input wire logic ale_i, // Latch strobe.
	input wire logic rd_n_i, // Read.
	input wire logic wr_n_i, // Store.
	output logic [7:0] ad_o // Pin level.
);
	logic [7:0] lat_reg;
	logic [7:0] mem [0:65535];
	always_latch if (ale_i) lat_reg <= ad_o;
	always @(posedge wr_n_i) mem[{addr_hi_i, lat_reg}] <= ad_o;
	// Released pins float up to the weak pull-ups.
	assign ad_o = ad_oe_i ? ad_out_i : !rd_n_i ? mem[{addr_hi_i, lat_reg}] : 8'hff;
endmodule : emx_mem_model

// File: emx_mux_ctrl.sv
`timescale 1ns/1ps
`include "emx_consts.svh"
// Function
// - Mode bit in configuration selects multiplexed or non-multiplexed operation.
// - Multiplexed mode carries data and low address byte on one bus.
// - Device drives the address latch strobe steering the external latch.
// - First phase: strobe high, low address byte driven on shared pins.
// - Strobe falling edge starts phase two; latch then holds its outputs.
// - Later in phase two data replaces address while read or store strobes.
// - Every external move is one code byte and takes three clocks.
module emx_mux_ctrl (
	input wire logic ref_clk_i, // System clock, 50 MHz.
	input wire logic srst_i, // Synchronous reset, active high.
	input wire logic clk_en_i, // Freezes all state while low.
	input wire logic [7:0] ext_mem_config_i, // Configuration byte.
	input wire logic req_valid_i, // Start an external move.
	input wire logic req_write_i, // One for store, zero for read.
	input wire logic req_wide_i, // One for 16-bit address form.
	input wire logic [15:0] req_addr_i, // Access address.
	input wire logic [7:0] req_wdata_i, // Store data.
	input wire logic [7:0] ad_in_i, // Shared pins, input side.
	output logic [7:0] ad_out_o, // Shared pins, output side.
	output logic ad_oe_o, // Shared pins driven when high.
	output logic [7:0] addr_hi_o, // Upper address byte.
	output logic [7:0] addr_lo_o, // Low address in non-multiplexed mode.
	output logic address_latch_strobe_o, // Address latch strobe.
	output logic read_strobe_n_o, // Read strobe, active low.
	output logic store_strobe_n_o, // Store strobe, active low.
	output logic req_ready_o, // Idle, request may be made.
	output logic rd_valid_o, // One-cycle pulse with read data.
	output logic [7:0] rd_data_o // Read data.
);

	emx_phase_if ph ();
	emx_pkg::emx_req_t req_reg;
	logic mux_mode_select;
	logic busy_reg;

	emx_phase_seq u_seq (
		.ref_clk_i(ref_clk_i),
		.srst_i(srst_i),
		.clk_en_i(clk_en_i),
		.ph(ph)
	);

	assign mux_mode_select = ext_mem_config_i[`EMX_CFG_MUX_BIT];
	assign ph.start = req_valid_i && !busy_reg;

	// ----------------------------------------
	// Request capture
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			req_reg <= '0;
			busy_reg <= 1'b0;
		end else if (clk_en_i) begin
			if (ph.start) begin
				req_reg.write <= req_write_i;
				req_reg.wide <= req_wide_i;
				// Narrow form only carries the low byte; upper byte reads zero.
				req_reg.addr <= req_wide_i ? req_addr_i : {8'h00, req_addr_i[7:0]};
				req_reg.wdata <= req_wdata_i;
				busy_reg <= 1'b1;
			end else if (ph.done) begin
				busy_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Pin phasing
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			ad_out_o <= 8'h00;
			ad_oe_o <= 1'b0;
			addr_hi_o <= 8'h00;
			addr_lo_o <= 8'h00;
			address_latch_strobe_o <= 1'b0;
			read_strobe_n_o <= 1'b1;
			store_strobe_n_o <= 1'b1;
		end else if (clk_en_i) begin
			if (ph.start) begin
				addr_hi_o <= req_wide_i ? req_addr_i[15:8] : 8'h00;
				read_strobe_n_o <= 1'b1;
				store_strobe_n_o <= 1'b1;
				if (mux_mode_select) begin
					address_latch_strobe_o <= 1'b1;
					ad_out_o <= req_addr_i[7:0];
					ad_oe_o <= 1'b1;
				end else begin
					address_latch_strobe_o <= 1'b0;
					addr_lo_o <= req_addr_i[7:0];
					ad_out_o <= req_wdata_i;
					ad_oe_o <= req_write_i;
				end
			end else if (busy_reg && ph.phase == 2'h1) begin
				// Address stays on the pins one cycle past the strobe fall for latch hold.
				address_latch_strobe_o <= 1'b0;
				read_strobe_n_o <= 1'b1;
				store_strobe_n_o <= 1'b1;
			end else if (busy_reg && ph.phase == 2'h2) begin
				ad_out_o <= req_reg.wdata;
				ad_oe_o <= req_reg.write;
				read_strobe_n_o <= req_reg.write;
				store_strobe_n_o <= !req_reg.write;
			end else if (ph.done) begin
				// Store data is held one cycle past the strobe rise for memory hold.
				read_strobe_n_o <= 1'b1;
				store_strobe_n_o <= 1'b1;
			end else if (!busy_reg) begin
				ad_oe_o <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Handshake and read return
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			req_ready_o <= 1'b0;
			rd_valid_o <= 1'b0;
			rd_data_o <= 8'h00;
		end else if (clk_en_i) begin
			req_ready_o <= !busy_reg && !ph.start || ph.done;
			rd_valid_o <= ph.done && !req_reg.write;
			if (ph.done && !req_reg.write) begin
				rd_data_o <= ad_in_i;
			end
		end
	end

endmodule : emx_mux_ctrl

// File: emx_mux_sva.sv
`timescale 1ns/1ps
module emx_mux_sva (
	input wire logic ref_clk_i, // Clock.
	input wire logic srst_i, // Reset.
	input wire logic clk_en_i, // Run.
	input wire logic [7:0] ext_mem_config_i, // Mode.
	input wire logic req_valid_i, // Request.
	input wire logic req_ready_o, // Idle.
	input wire logic ad_oe_o, // Pin drive.
	input wire logic address_latch_strobe_o, // Latch strobe.
	input wire logic read_strobe_n_o, // Read.
	input wire logic store_strobe_n_o, // Store.
	input wire logic rd_valid_o // Read data valid.
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);
	wire logic go = req_valid_i && req_ready_o && clk_en_i;
	mux_start_a: assert property (go && ext_mem_config_i[4] |=> address_latch_strobe_o)
		else $error("strobe missing");
	flat_mode_a: assert property (go && !ext_mem_config_i[4] |=> !address_latch_strobe_o[*3])
		else $error("strobe in flat mode");
	strobe_width_a: assert property (address_latch_strobe_o |=> !address_latch_strobe_o)
		else $error("strobe too long");
	addr_drive_a: assert property (address_latch_strobe_o |-> ad_oe_o)
		else $error("address not driven");
	quiet_first_a: assert property (address_latch_strobe_o |-> read_strobe_n_o && store_strobe_n_o)
		else $error("strobe in first phase");
	phase_gap_a: assert property ($fell(address_latch_strobe_o) |=> !(read_strobe_n_o && store_strobe_n_o))
		else $error("no data strobe");
	read_float_a: assert property (!read_strobe_n_o |-> !ad_oe_o)
		else $error("pins driven in read");
	store_drive_a: assert property (!store_strobe_n_o |-> ad_oe_o)
		else $error("pins idle in store");
	read_done_a: assert property ($fell(read_strobe_n_o) |-> ##[1:3] rd_valid_o)
		else $error("read too slow");
	cover property (go && ext_mem_config_i[4]);
	cover property (!read_strobe_n_o);
	cover property (!store_strobe_n_o);
endmodule : emx_mux_sva
bind emx_mux_ctrl emx_mux_sva u_sva (.ref_clk_i, .srst_i, .clk_en_i, .ext_mem_config_i,
	.req_valid_i, .req_ready_o, .ad_oe_o, .address_latch_strobe_o, .read_strobe_n_o,
	.store_strobe_n_o, .rd_valid_o);

// File: emx_phase_if.sv
`timescale 1ns/1ps
interface emx_phase_if;
	logic start;
	logic done;
	logic [1:0] phase;

	modport ctrl (output start, input done, input phase);
	modport seq (input start, output done, output phase);
endinterface : emx_phase_if

// File: emx_phase_seq.sv
`timescale 1ns/1ps
`include "emx_consts.svh"
module emx_phase_seq (
	input wire logic ref_clk_i, // System clock.
	input wire logic srst_i, // Synchronous reset.
	input wire logic clk_en_i, // Clock enable.
	emx_phase_if.seq ph // Phase handshake.
);

	logic [1:0] cnt_reg;
	logic busy_reg;

	// ----------------------------------------
	// Three-cycle access counter
	// ----------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			cnt_reg <= 2'h0;
			busy_reg <= 1'b0;
		end else if (clk_en_i) begin
			if (!busy_reg && ph.start) begin
				busy_reg <= 1'b1;
				cnt_reg <= 2'h1;
			end else if (busy_reg && cnt_reg == 2'(`EMX_MOVE_CYCLES)) begin
				busy_reg <= 1'b0;
				cnt_reg <= 2'h0;
			end else if (busy_reg) begin
				cnt_reg <= cnt_reg + 2'h1;
			end
		end
	end

	assign ph.phase = cnt_reg;
	assign ph.done = busy_reg && cnt_reg == 2'(`EMX_MOVE_CYCLES);

endmodule : emx_phase_seq

// File: emx_pkg.sv
package emx_pkg;

	typedef enum logic [1:0] {
		EMX_IDLE,
		EMX_ADDR,
		EMX_DATA,
		EMX_LAST
	} emx_state_t;

	typedef struct packed {
		logic write;
		logic wide;
		logic [15:0] addr;
		logic [7:0] wdata;
	} emx_req_t;

endpackage : emx_pkg

// File: ext_mem_mux_phasing_bench.sv
`timescale 1ns/1ps
module ext_mem_mux_phasing_bench;
	logic ref_clk_i = 0, srst_i = 1, req_valid_i = 0, req_write_i = 0, req_wide_i = 0;
	logic [7:0] cfg = 8'h10, wdata = 8'h00, ad_in, ad_out, hi, rd_data;
	logic [15:0] addr = 16'h0000;
	logic oe, ale, rd_n, wr_n, ready, rd_valid;
	logic [7:0] exp_q[$], d_q[$];
	logic [15:0] a_q[$];
	int fails = 0, checks_done = 0, cyc = 0;
	always #10 ref_clk_i = ~ref_clk_i;
	emx_mux_ctrl u_dut (.ref_clk_i, .srst_i, .clk_en_i(1'b1), .ext_mem_config_i(cfg),
		.req_valid_i, .req_write_i, .req_wide_i, .req_addr_i(addr), .req_wdata_i(wdata),
		.ad_in_i(ad_in), .ad_out_o(ad_out), .ad_oe_o(oe), .addr_hi_o(hi), .addr_lo_o(),
		.address_latch_strobe_o(ale), .read_strobe_n_o(rd_n), .store_strobe_n_o(wr_n),
		.req_ready_o(ready), .rd_valid_o(rd_valid), .rd_data_o(rd_data));
	emx_mem_model u_mem (.ad_out_i(ad_out), .ad_oe_i(oe), .addr_hi_i(hi), .ale_i(ale),
		.rd_n_i(rd_n), .wr_n_i(wr_n), .ad_o(ad_in));
	task chk(input string n, input logic [15:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk
	task final_report;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : final_report
	task acc(input logic w, input logic [15:0] a, input logic [7:0] d);
		int n;
		n = 0;
		while (ready !== 1'b1 && n < 50) begin
			@(negedge ref_clk_i);
			n++;
		end
		{req_write_i, addr, wdata, req_valid_i, req_wide_i} = {w, a, d, 1'b1, |a[15:8]};
		if (!w) exp_q.push_back(d);
		@(negedge ref_clk_i);
		req_valid_i = 0;
		@(negedge ref_clk_i);
	endtask : acc
	always @(negedge ref_clk_i) begin
		cyc++;
		if (cyc > 3000) begin
			fails++;
			final_report();
		end
		if (rd_valid === 1'b1) chk("rd_data", rd_data, exp_q.pop_front());
	end
	initial begin
		void'($urandom(32'h644bd84d));
		repeat (2) @(negedge ref_clk_i);
		srst_i = 0;
		for (int i = 0; i < 8; i++) begin
			cfg = 8'($urandom) | 8'h10;
			a_q.push_back({i[0] ? 8'h00 : 8'($urandom), 8'(i * 37 + 1)});
			d_q.push_back(8'($urandom));
			acc(1, a_q[i], d_q[i]);
		end
		for (int i = 7; i >= 0; i--) acc(0, a_q[i], d_q[i]);
		cfg = 8'hef;
		acc(1, 16'h12fe, 8'h3c);
		repeat (10) @(negedge ref_clk_i);
		chk("reads_left", 16'(exp_q.size()), 16'h0000);
		final_report();
	end
endmodule : ext_mem_mux_phasing_bench
